// ===== inc/icc_pkg.sv
// Constants and types shared by the input capture channel block.
// Assumes a single core clock domain; no register bus, plain ports only.
package icc_pkg;

  localparam int NUM_CHAN   = 4;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W      = 3;
  localparam int PRE_W      = 4;
  localparam int ICI_W      = 2;

  typedef enum logic [2:0] {
    MODE_OFF    = 3'h0,
    MODE_BOTH   = 3'h1,
    MODE_FALL   = 3'h2,
    MODE_RISE   = 3'h3,
    MODE_RISE4  = 3'h4,
    MODE_RISE16 = 3'h5,
    MODE_RSVD   = 3'h6,
    MODE_WAKE   = 3'h7
  } icc_mode_t;

  // Prescaler terminal counts: 4th and 16th rising edge
  localparam logic [PRE_W-1:0] PRE_RESET  = 4'h0;
  localparam logic [PRE_W-1:0] PRE4_LAST  = 4'h3;
  localparam logic [PRE_W-1:0] PRE16_LAST = 4'hF;

  // time_base_select: 1 picks base a, 0 (the reset default) picks base b
  localparam logic TB_SEL_A = 1'b1;

  localparam logic [ICI_W-1:0]  ICI_CNT_RESET = 2'h0;
  localparam logic [CNT_W-1:0]  FILL_RESET    = 3'h0;
  localparam logic [CNT_W-1:0]  FILL_FULL     = 3'h4;
  localparam logic [WORD_W-1:0] WORD_RESET    = 16'h0000;
  localparam logic [1:0]        SYNC_RESET    = 2'h0;

endpackage : icc_pkg

// ===== inc/icc_evt_if.sv
// Carries one channel's mode and qualified edge events between the
// channel logic and its edge/prescaler generator. Single clock domain.
`timescale 1ns/1ps
`default_nettype none

interface icc_evt_if;
  import icc_pkg::*;

  icc_mode_t mode;     // Channel capture mode
  logic      pre_run;  // Prescaler may count
  logic      cap_evt;  // Qualified capture event, one-cycle pulse

  modport gen
  (
    input  mode,
    input  pre_run,
    output cap_evt
  );

  modport sink
  (
    output mode,
    output pre_run,
    input  cap_evt
  );
endinterface : icc_evt_if

`default_nettype wire

// ===== src/icc_event_gen.sv
// Pin synchroniser, edge detector and edge prescaler of one channel.
// Pin is asynchronous to core_clk; mode comes from core_clk logic.
`timescale 1ns/1ps
`default_nettype none

module icc_event_gen
  import icc_pkg::*;
(
  input  wire logic core_clk,   // Core clock
  input  wire logic rst,        // Async reset, active high
  input  wire logic pin_async,  // Raw capture pin
  icc_evt_if.gen    evt         // Mode in, event out
);

  logic [1:0]       sync_reg;
  logic             last_reg;
  logic [PRE_W-1:0] pre_reg;
  logic             rise;
  logic             fall;

  // Only the second stage is looked at
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_reg <= SYNC_RESET;
      last_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= {sync_reg[0], pin_async};
      last_reg <= sync_reg[1];
    end
  end

  assign rise = sync_reg[1] & ~last_reg;
  assign fall = ~sync_reg[1] & last_reg;

  // Off or reset clears the edge count
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pre_reg <= PRE_RESET;
    else if (evt.mode == MODE_OFF)
      pre_reg <= PRE_RESET;
    else if (rise && evt.pre_run)
    begin
      if ((evt.mode == MODE_RISE4 && pre_reg == PRE4_LAST) ||
          (evt.mode == MODE_RISE16 && pre_reg == PRE16_LAST))
        pre_reg <= PRE_RESET;
      else
        pre_reg <= pre_reg + 4'h1;
    end
  end

  // Edge selection per mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      evt.cap_evt <= 1'b0;
    else
    begin
      case (evt.mode)
        MODE_BOTH:   evt.cap_evt <= rise | fall;
        MODE_FALL:   evt.cap_evt <= fall;
        MODE_RISE:   evt.cap_evt <= rise;
        MODE_WAKE:   evt.cap_evt <= rise;
        MODE_RISE4:  evt.cap_evt <= rise && evt.pre_run &&
                                    pre_reg == PRE4_LAST;
        MODE_RISE16: evt.cap_evt <= rise && evt.pre_run &&
                                    pre_reg == PRE16_LAST;
        default:     evt.cap_evt <= 1'b0;  // Off and reserved
      endcase
    end
  end

endmodule : icc_event_gen

`default_nettype wire

// ===== src/icc_capture_top.sv
// Four-channel input capture: timestamps pin edges into per-channel FIFOs.
// Time bases, power state and control bits come from core_clk logic.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Four channels, indices map to ids 1,2,7,8
// - Mode picks falling, rising, 4th, 16th, both
// - Prescaler cleared when off and on reset
// - Each channel buffers four 16-bit words
// - Not-empty flag set until all read
// - Read gives oldest word, rest advance
// - Fifth event sets overrun, word dropped
// - After overrun, ignore events until drained
// - Select bit picks time base, default b
// - Both-edges mode interrupts every edge
// - Both-edges mode never flags overrun
// - Enabled interrupt in idle or sleep wakes device
// - Mode 111 wakes regardless of timer state
// - In sleep only mode 111 rising edges
// - Two-bit field sets events per interrupt
// - Idle keeps function if timer on, no halt
// - Per-channel interrupt flag and enable
module icc_capture_top
  import icc_pkg::*;
(
  input  wire logic                   core_clk,             // Core clock
  input  wire logic                   rst,                  // Async reset
  input  wire logic [NUM_CHAN-1:0]    capture_pin,          // Capture pins
  input  wire logic [WORD_W-1:0]      time_base_a,          // First timer
  input  wire logic [WORD_W-1:0]      time_base_b,          // Second timer
  input  wire logic                   time_base_a_on,       // First runs
  input  wire logic                   time_base_b_on,       // Second runs
  input  wire logic                   cpu_idle,             // CPU in idle
  input  wire logic                   cpu_sleep,            // CPU asleep
  input  wire logic [NUM_CHAN-1:0][2:0] capture_mode_sel,   // Modes
  input  wire logic [NUM_CHAN-1:0]    time_base_select,     // 1 = base a
  input  wire logic [NUM_CHAN-1:0][ICI_W-1:0] events_per_irq_sel, // Rate
  input  wire logic [NUM_CHAN-1:0]    halt_when_idle,       // Stop in idle
  input  wire logic [NUM_CHAN-1:0]    capture_irq_enable,   // Irq enables
  input  wire logic [NUM_CHAN-1:0]    buf_rd,               // Read pulses
  input  wire logic [NUM_CHAN-1:0]    irq_flag_clr,         // Flag clears
  input  wire logic [NUM_CHAN-1:0]    overrun_clr,          // Overrun clears
  output logic      [NUM_CHAN-1:0][WORD_W-1:0] buf_data,    // Oldest words
  output logic      [NUM_CHAN-1:0]    buf_nonempty_flag,    // Data held
  output logic      [NUM_CHAN-1:0]    capture_overrun_flag, // Overrun seen
  output logic      [NUM_CHAN-1:0]    capture_irq_flag,     // Irq flags
  output logic                        wake_req              // Wake pulse
);

  function automatic logic [WORD_W-1:0] tb_pick
  (
    input logic              sel,
    input logic [WORD_W-1:0] a,
    input logic [WORD_W-1:0] b
  );
    tb_pick = (sel == TB_SEL_A) ? a : b;
  endfunction : tb_pick

  logic [NUM_CHAN-1:0] wake_hit;
  logic                wake_req_reg;

  // Index 0..3 stand for channel ids 1, 2, 7, 8
  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : g_chan
    icc_evt_if ev ();

    logic [WORD_W-1:0] fifo_reg [FIFO_DEPTH];
    logic [CNT_W-1:0]  fill_reg;
    logic [CNT_W-1:0]  fill_next;
    logic              nonempty_reg;
    logic              overrun_reg;
    logic              lock_reg;
    logic              irq_reg;
    logic [ICI_W-1:0]  ici_cnt_reg;
    icc_mode_t         mode;
    logic              tb_on;
    logic              full_run;
    logic              wake_only;
    logic              store_evt;
    logic              rd_eff;
    logic              full;
    logic              wr;
    logic              ovf_evt;
    logic              irq_hit;
    logic [CNT_W-1:0]  wr_idx;

    assign mode  = icc_mode_t'(capture_mode_sel[c]);
    assign tb_on = (time_base_select[c] == TB_SEL_A) ? time_base_a_on
                                                     : time_base_b_on;

    // Idle keeps full function only with timer on and no halt
    // Sleep stops all but the interrupt-only path
    assign full_run  = !cpu_sleep &&
                       (!cpu_idle || (tb_on && !halt_when_idle[c]));
    // Mode 111 in a low-power state bypasses timer and rate
    assign wake_only = (cpu_sleep || cpu_idle) && mode == MODE_WAKE;

    assign ev.mode    = mode;
    assign ev.pre_run = full_run && !wake_only;

    icc_event_gen u_gen
    (
      .core_clk  (core_clk),
      .rst       (rst),
      .pin_async (capture_pin[c]),
      .evt       (ev)
    );

    // Events are dropped while locked after an overrun
    assign store_evt = ev.cap_evt && full_run && !wake_only && !lock_reg;
    // Empty reads leave the buffer untouched
    assign rd_eff    = buf_rd[c] && fill_reg != FILL_RESET;
    assign full      = fill_reg == FILL_FULL;
    // A read in the same cycle frees a slot for the new word
    assign wr        = store_evt && (!full || rd_eff);
    // Both-edges mode drops silently
    assign ovf_evt   = store_evt && full && !rd_eff && mode != MODE_BOTH;
    assign fill_next = fill_reg + CNT_W'(wr) - CNT_W'(rd_eff);
    assign wr_idx    = fill_reg - CNT_W'(rd_eff);

    // Shift toward the head on read, append at tail
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        for (int i = 0; i < FIFO_DEPTH; i++)
          fifo_reg[i] <= WORD_RESET;
      end
      else
      begin
        if (rd_eff)
        begin
          for (int i = 0; i < FIFO_DEPTH - 1; i++)
            fifo_reg[i] <= fifo_reg[i+1];
        end
        if (wr)
          fifo_reg[wr_idx[1:0]] <= tb_pick(time_base_select[c],
                                           time_base_a, time_base_b);
      end
    end

    // Fill level and not-empty flag
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        fill_reg     <= FILL_RESET;
        nonempty_reg <= 1'b0;
      end
      else
      begin
        fill_reg     <= fill_next;
        nonempty_reg <= fill_next != FILL_RESET;
      end
    end

    // Overrun flag: set wins over clear
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        overrun_reg <= 1'b0;
      else if (ovf_evt)
        overrun_reg <= 1'b1;
      else if (overrun_clr[c])
        overrun_reg <= 1'b0;
    end

    // Capture lock lasts until the buffer is drained
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        lock_reg <= 1'b0;
      else if (ovf_evt)
        lock_reg <= 1'b1;
      else if (fill_next == FILL_RESET)
        lock_reg <= 1'b0;
    end

    // Interrupt rate: every Nth stored event, N = field + 1
    // Both-edges mode ignores the rate field
    always_comb
    begin
      irq_hit = 1'b0;
      if (wake_only)
        irq_hit = ev.cap_evt;
      else if (store_evt)
        irq_hit = (mode == MODE_BOTH) ||
                  (ici_cnt_reg == events_per_irq_sel[c]);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        ici_cnt_reg <= ICI_CNT_RESET;
      else if (mode == MODE_OFF || mode == MODE_BOTH)
        ici_cnt_reg <= ICI_CNT_RESET;
      else if (store_evt && !wake_only)
      begin
        if (ici_cnt_reg == events_per_irq_sel[c])
          ici_cnt_reg <= ICI_CNT_RESET;
        else
          ici_cnt_reg <= ici_cnt_reg + 2'h1;
      end
    end

    // Sticky interrupt flag, set wins over clear
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        irq_reg <= 1'b0;
      else if (irq_hit)
        irq_reg <= 1'b1;
      else if (irq_flag_clr[c])
        irq_reg <= 1'b0;
    end

    // Low-power event with enable asks for wake-up
    assign wake_hit[c] = irq_hit && capture_irq_enable[c] &&
                         (cpu_idle || cpu_sleep);

    assign buf_data[c]             = fifo_reg[0];
    assign buf_nonempty_flag[c]    = nonempty_reg;
    assign capture_overrun_flag[c] = overrun_reg;
    assign capture_irq_flag[c]     = irq_reg;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wake_req_reg <= 1'b0;
    else
      wake_req_reg <= |wake_hit;
  end

  assign wake_req = wake_req_reg;

endmodule : icc_capture_top

`default_nettype wire

// ===== bench/icc_capture_assertions.sv
// Checker on channel 0 and the shared wake request of the capture block, ports only.
// Bound into icc_capture_top; single clock domain.
`timescale 1ns/1ps
`default_nettype none

module icc_capture_assertions
(
  input wire logic             core_clk,             // Clock
  input wire logic             rst,                  // Async reset
  input wire logic [3:0][2:0]  capture_mode_sel,     // Modes
  input wire logic             cpu_idle,             // Idle
  input wire logic             cpu_sleep,            // Sleep
  input wire logic [3:0]       capture_irq_enable,   // Enables
  input wire logic [3:0]       buf_rd,               // Reads
  input wire logic [3:0]       irq_flag_clr,         // Flag clears
  input wire logic [3:0]       overrun_clr,          // Overrun clears
  input wire logic [3:0]       buf_nonempty_flag,    // Data held
  input wire logic [3:0]       capture_overrun_flag, // Overrun
  input wire logic [3:0]       capture_irq_flag,     // Irq flags
  input wire logic             wake_req              // Wake pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Four cycles covers the whole pin-to-store pipeline
  sequence s_off;
    (capture_mode_sel[0] == 3'h0) [*4];
  endsequence
  sequence s_asleep;
    cpu_sleep [*4];
  endsequence

  property p_off_quiet;
    s_off |-> !$rose(capture_irq_flag[0]);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("irq flag rose while channel off");
  property p_sleep_nostore;
    s_asleep |-> !$rose(buf_nonempty_flag[0]);
  endproperty
  a_sleep_nostore: assert property (p_sleep_nostore)
    else $error("word stored during sleep");
  property p_wake_once;
    wake_req |=> !wake_req;
  endproperty
  a_wake_once: assert property (p_wake_once)
    else $error("wake request longer than one cycle");
  property p_wake_cause;
    wake_req |-> ($past(cpu_sleep) || $past(cpu_idle))
      && (|$past(capture_irq_enable));
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake request without idle or enable");
  property p_nonempty_drop;
    $fell(buf_nonempty_flag[0]) |-> $past(buf_rd[0]);
  endproperty
  a_nonempty_drop: assert property (p_nonempty_drop)
    else $error("not-empty flag dropped without a read");
  property p_ovr_mode;
    $rose(capture_overrun_flag[0]) |-> $past(capture_mode_sel[0]) != 3'h1;
  endproperty
  a_ovr_mode: assert property (p_ovr_mode)
    else $error("overrun raised in both-edges mode");
  property p_ovr_hold;
    capture_overrun_flag[0] && !overrun_clr[0] |=> capture_overrun_flag[0];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("overrun flag lost without clear");
  property p_irq_hold;
    capture_irq_flag[0] && !irq_flag_clr[0] |=> capture_irq_flag[0];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq flag lost without clear");
endmodule : icc_capture_assertions

bind icc_capture_top icc_capture_assertions u_icc_capture_assertions (.*);

`default_nettype wire

// ===== bench/icc_pin_model.sv
// Sensor signals on the capture pins.
// Follows the bench's requested level, off the clock edge.
`timescale 1ns/1ps
`default_nettype none

module icc_pin_model
(
  input  wire logic       core_clk, // Bench clock
  input  wire logic [3:0] lvl,      // Requested levels
  output logic      [3:0] pin       // Pin levels
);
  initial pin = 4'h0;
  // Varying skew so edges are truly asynchronous to the core
  always @(posedge core_clk)
    pin <= #(1 + $urandom % 6) lvl;
endmodule : icc_pin_model

`default_nettype wire

// ===== bench/input_capture_channels_test.sv
// Self-checking bench for the four-channel capture block.
// Pins come from the pin model; time bases held per test.
`timescale 1ns/1ps
`default_nettype none

module input_capture_channels_test;
  import icc_pkg::*;
  logic core_clk, rst, cpu_idle, cpu_sleep, ton, woke, wk;
  logic [3:0] lvl, pin, tsel, halt, ien, rd, iclr, oclr, ne, ov, ifl;
  logic [3:0][2:0] mode;
  logic [3:0][1:0] ici;
  logic [3:0][15:0] bd;
  logic [15:0] ta, tb;
  int miscompares, total_checks;
  // Mode, pulses, power: 0 run, 1 sleep, 2 idle with halt
  int tab [15][3] = '{'{3,5,0}, '{2,3,0}, '{4,14,0}, '{5,15,0},
    '{7,1,1}, '{1,3,0}, '{7,3,0}, '{0,3,0}, '{1,5,0}, '{3,1,2},
    '{6,3,0}, '{7,1,2}, '{3,3,1}, '{2,5,0}, '{4,2,0}};

  icc_pin_model u_icc_pin_model (.core_clk(core_clk), .lvl(lvl), .pin(pin));
  icc_capture_top u_icc_capture_top (.core_clk(core_clk), .rst(rst),
    .capture_pin(pin), .time_base_a(ta), .time_base_b(tb),
    .time_base_a_on(ton), .time_base_b_on(ton), .cpu_idle(cpu_idle),
    .cpu_sleep(cpu_sleep), .capture_mode_sel(mode), .time_base_select(tsel),
    .events_per_irq_sel(ici), .halt_when_idle(halt),
    .capture_irq_enable(ien), .buf_rd(rd), .irq_flag_clr(iclr),
    .overrun_clr(oclr), .buf_data(bd), .buf_nonempty_flag(ne),
    .capture_overrun_flag(ov), .capture_irq_flag(ifl), .wake_req(wk));

  initial
  begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
    if (wk === 1'h1) woke <= 1'h1;

  task automatic chk_w(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_f(input string nm, input logic e, g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_f

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Qualifying events for n pulses plus one final rise
  function automatic int ev_cnt(int m, int n);
    case (m)
      1: return 2 * n + 1;
      2: return n;
      3, 7: return n + 1;
      4: return (n + 1) / 4;
      5: return (n + 1) / 16;
      default: return 0;
    endcase
  endfunction : ev_cnt

  initial
  begin
    int c, m, n, pw, e, k;
    logic s, en, xi;
    logic [1:0] r;
    {cpu_idle, cpu_sleep, woke, lvl, tsel, halt, ien, rd, iclr, oclr} = '0;
    {mode, ici, ta, tb} = '0;
    ton = 1'h1;
    rst = 1'h1;
    void'($urandom(32'he617_7db3));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    chk_f("nonempty at reset", 1'h0, ne[0]);
    for (int t = 0; t < 15; t++)
    begin
      c = t % 4;
      m = tab[t][0];
      n = tab[t][1];
      pw = tab[t][2];
      s = $urandom;
      r = $urandom;
      en = $urandom | (t == 4);
      @(posedge core_clk);
      ta <= $urandom;
      tb <= $urandom;
      mode[c] <= m[2:0];
      tsel[c] <= s;
      ici[c] <= r;
      ien[c] <= en;
      halt[c] <= (pw == 2);
      // Timer state must not matter outside idle
      ton <= $urandom;
      cpu_sleep <= (pw == 1);
      cpu_idle <= (pw == 2);
      woke <= 1'h0;
      repeat (4) @(posedge core_clk);
      repeat (n)
      begin
        lvl[c] <= 1'h1;
        repeat (4) @(posedge core_clk);
        lvl[c] <= 1'h0;
        repeat (4) @(posedge core_clk);
      end
      lvl[c] <= 1'h1;
      repeat (8) @(posedge core_clk);
      #1;
      e = (pw != 0 && m != 7) ? 0 : ev_cnt(m, n);
      xi = pw != 0 ? e > 0 : e >= (m == 1 ? 1 : r + 1);
      chk_f("irq", xi, ifl[c]);
      chk_f("overrun", pw == 0 && m != 1 && e > 4, ov[c]);
      chk_f("wake", pw != 0 && m == 7 && en, woke);
      @(posedge core_clk);
      mode[c] <= 3'h0;
      cpu_sleep <= 1'h0;
      cpu_idle <= 1'h0;
      lvl[c] <= 1'h0;
      #1;
      k = 0;
      while (k < 8 && ne[c] === 1'h1)
      begin
        chk_w("word", s ? ta : tb, bd[c]);
        k++;
        @(posedge core_clk);
        rd[c] <= 1'h1;
        @(posedge core_clk);
        rd[c] <= 1'h0;
        #1;
      end
      chk_w("count", (pw != 0) ? 0 : (e > 4 ? 4 : e), k[15:0]);
      @(posedge core_clk);
      iclr[c] <= 1'h1;
      oclr[c] <= 1'h1;
      @(posedge core_clk);
      iclr[c] <= 1'h0;
      oclr[c] <= 1'h0;
      // Final fall must clear the synchroniser while the channel is off,
      // else the next falling or both-edges test sees a stale edge
      repeat (4) @(posedge core_clk);
      $display("test %0d done", t);
    end
    complete_run();
  end
endmodule : input_capture_channels_test

`default_nettype wire
